//--- design/ihc_pkg.sv
// package for the input function and homing control block
package ihc_pkg;
    // ************************************************************
    // register map (AXI4-Lite byte addresses)
    // ************************************************************
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_PRESET = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_MPOS = 8'h10;
    localparam logic [7:0] ADDR_EPOS = 8'h14;
    localparam logic [7:0] ADDR_CAPT = 8'h18;
    localparam logic [7:0] ADDR_GEAR = 8'h1C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // input functions, 3 bits per input in cfg[8:0], polarity cfg[11:9]
    // ************************************************************
    localparam logic [2:0] FN_GP = 3'h0;
    localparam logic [2:0] FN_CWLIM = 3'h1;
    localparam logic [2:0] FN_CCWLIM = 3'h2;
    localparam logic [2:0] FN_START = 3'h3;
    localparam logic [2:0] FN_ESTOP = 3'h4;
    localparam logic [2:0] FN_STOPJOG = 3'h5;
    localparam logic [2:0] FN_HOME = 3'h6;
    localparam int CFG_POL = 9;
    localparam int CFG_ENC = 12;
    localparam int CFG_GEAR = 13;
    localparam int CFG_PROX = 14;

    // ************************************************************
    // command bits (write pulses)
    // ************************************************************
    localparam int CMD_JOG_CW = 0;
    localparam int CMD_JOG_CCW = 1;
    localparam int CMD_REG = 2;
    localparam int CMD_IDX = 3;
    localparam int CMD_HOME_CW = 4;
    localparam int CMD_HOME_CCW = 5;
    localparam int CMD_STOP = 6;
    localparam int CMD_RESET_ERR = 7;
    localparam int CMD_PROX = 8;
    localparam int CMD_IDX_DIR = 9;

    localparam int POS_W = 24;
    localparam int PAUSE_MS = 2000;
    localparam int CLK_KHZ = 20000;
    localparam int PAUSE_CYC = PAUSE_MS * CLK_KHZ;

    typedef enum logic [8:0] {
        IHC_IDLE = 9'h001,
        IHC_RUN = 9'h002,
        IHC_H_FWD = 9'h004,
        IHC_H_DEC1 = 9'h008,
        IHC_H_P1 = 9'h010,
        IHC_H_REV = 9'h020,
        IHC_H_P2 = 9'h040,
        IHC_H_RET = 9'h080,
        IHC_H_SLOW = 9'h100
    } ihc_state_e;

    // motion request to the profile generator
    typedef struct packed {
        logic run;
        logic dir_ccw;
        logic slow;
        logic halt_now;
        logic ramp_stop;
    } ihc_motion_s;
endpackage : ihc_pkg

//--- design/ihc_top.sv
// input function assignment, stop logic, capture and homing sequencer
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - limit matching travel direction halts jog, registration and index moves at once, no ramp.
// - after a limit halt only motion away from that limit is accepted.
// - indexer move waits pending until a start input goes inactive to active.
// - encoder mode with input 3 as start captures position on every edge.
// - emergency halt input stops motion immediately; drive stays enabled.
// - no move begins while emergency halt input is active.
// - stop-jog rising edge ramps down manual or registration moves only.
// - encoder mode with input 3 stop-jog captures only on an effective stop.
// - gearing moves motor by encoder change scaled by programmable ratio.
// - general purpose inputs do not affect motion; states are reported.
// - preset loads the signed 24-bit motor position register.
// - homing runs until home active, ramps down, stops, pauses 2 s.
// - after first pause run reverse at speed until home releases.
// - on home release during reverse, ramp to stop and pause 2 s.
// - return at starting speed and stop exactly on home activating.
// - overtravel during the first forward homing run stops at once, pauses, then reverse phases.
// - home already active: reverse until release, pause, slow return.
// - overtravel already active: start directly with reverse run.
// - counter-clockwise homing mirrors directions and overtravel limit.
// - proximity homing ignores home until proximity flag rises after start.
// - proximity rise ramps to starting speed, then stops on home activation.
// - each input function and active polarity is configurable.
module ihc_top #(
    parameter int PAUSE_CYCLES = ihc_pkg::PAUSE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] pin_in,
    input wire logic profile_done,
    input wire logic step_pulse,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output ihc_pkg::ihc_motion_s motion,
    output logic drive_enable,
    output logic gear_step,
    output logic gear_dir_ccw
);
    import ihc_pkg::*;

    typedef struct packed {
        logic [2:0] sync1, sync2, act_q;
        logic [31:0] cfg;
        logic [31:0] gear_ratio;
        logic [POS_W-1:0] mpos, epos, capt;
        logic [31:0] gear_acc;
        ihc_state_e st;
        logic dir_ccw, mv_jog, idx_pend, idx_dir, prox_q, prox_seen, lim_cw_err, lim_ccw_err;
        logic [31:0] pause_cnt;
        ihc_motion_s mot;
        logic gstep, gdir;
        logic aw_hold, w_hold;
        logic [7:0] awa;
        logic [31:0] wd;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } ihc_reg_s;
    ihc_reg_s r, next_r;

    // ************************************************************
    // per-input qualification
    // ************************************************************
    logic [2:0] act, rise, tog, fn_cw, fn_ccw, fn_start, fn_estop, fn_stop, fn_home;
    // each input has its own function field and polarity bit
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_in
            logic [2:0] fn;
            logic enc_lost;
            assign fn = r.cfg[3*gi +: 3];
            assign act[gi] = r.sync2[gi] ^ r.cfg[CFG_POL + gi];
            assign rise[gi] = act[gi] & ~r.act_q[gi];
            assign tog[gi] = act[gi] ^ r.act_q[gi];
            // inputs 1,2 lose their discrete function in encoder mode
            assign enc_lost = r.cfg[CFG_ENC] && (gi < 2);
            assign fn_cw[gi] = !enc_lost && fn == FN_CWLIM;
            assign fn_ccw[gi] = !enc_lost && fn == FN_CCWLIM;
            assign fn_start[gi] = !enc_lost && fn == FN_START;
            assign fn_estop[gi] = !enc_lost && fn == FN_ESTOP;
            assign fn_stop[gi] = !enc_lost && fn == FN_STOPJOG;
            assign fn_home[gi] = !enc_lost && fn == FN_HOME;
        end
    endgenerate
    logic lim_cw, lim_ccw, estop, estop_rise, start_rise, stop_rise, home_act, home_rise, home_fall, prox_en;
    assign lim_cw = |(act & fn_cw);
    assign lim_ccw = |(act & fn_ccw);
    assign estop = |(act & fn_estop);
    assign estop_rise = |(rise & fn_estop);
    assign start_rise = |(rise & fn_start);
    assign stop_rise = |(rise & fn_stop);
    assign home_act = |(act & fn_home);
    assign home_rise = |(rise & fn_home);
    assign home_fall = |(~act & r.act_q & fn_home);
    assign prox_en = r.cfg[CFG_PROX];

    // quadrature decode of synchronised phases
    logic [1:0] qa_ab, qa_prev;
    logic q_up, q_dn;
    assign qa_ab = {r.sync2[0], r.sync2[1]};
    assign qa_prev = {r.act_q[0] ^ r.cfg[CFG_POL], r.act_q[1] ^ r.cfg[CFG_POL + 1]};
    assign q_up = r.cfg[CFG_ENC] && ((qa_prev == 2'h0 && qa_ab == 2'h2) || (qa_prev == 2'h2 && qa_ab == 2'h3) ||
                  (qa_prev == 2'h3 && qa_ab == 2'h1) || (qa_prev == 2'h1 && qa_ab == 2'h0));
    assign q_dn = r.cfg[CFG_ENC] && ((qa_prev == 2'h0 && qa_ab == 2'h1) || (qa_prev == 2'h1 && qa_ab == 2'h3) ||
                  (qa_prev == 2'h3 && qa_ab == 2'h2) || (qa_prev == 2'h2 && qa_ab == 2'h0));

    // ************************************************************
    // bus write/read decode helpers
    // ************************************************************
    logic wr_fire, rd_fire;
    logic [31:0] cmd;
    assign wr_fire = r.aw_hold && r.w_hold && !r.bvalid;
    assign rd_fire = s_axi_arvalid && !r.rvalid;
    assign cmd = (wr_fire && r.awa == ADDR_CMD) ? r.wd : 32'h0;

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        logic moving, begin_ok, h_ccw, ot_fwd;
        logic [32:0] gsum;
        gsum = 33'h0;
        h_ccw = r.dir_ccw;
        ot_fwd = h_ccw ? lim_ccw : lim_cw;
        moving = r.st != IHC_IDLE;
        begin_ok = !estop && !moving;
        next_r = r;
        next_r.sync1 = pin_in;
        next_r.sync2 = r.sync1;
        next_r.act_q = act;
        next_r.mot.halt_now = 1'b0;
        next_r.mot.ramp_stop = 1'b0;
        next_r.gstep = 1'b0;
        next_r.prox_q = 1'b0;
        // encoder count and step-based motor position
        if (q_up) next_r.epos = r.epos + 1'b1;
        else if (q_dn) next_r.epos = r.epos - 1'b1;
        if (step_pulse) next_r.mpos = r.mot.dir_ccw ? r.mpos - 1'b1 : r.mpos + 1'b1;
        // gearing: accumulate ratio per encoder count, step on carry
        if (r.cfg[CFG_GEAR] && (q_up || q_dn) && !estop) begin
            gsum = {1'b0, r.gear_acc} + {1'b0, r.gear_ratio};
            next_r.gear_acc = gsum[31:0];
            next_r.gstep = gsum[32];
            next_r.gdir = q_dn;
        end
        // capture on input 3 in encoder mode
        if (r.cfg[CFG_ENC] && fn_start[2] && tog[2]) next_r.capt = r.epos;
        if (r.cfg[CFG_ENC] && fn_stop[2] && rise[2] && r.st == IHC_RUN && r.mv_jog)
            next_r.capt = r.epos;
        // proximity edge, held only after homing starts
        if (cmd[CMD_PROX]) next_r.prox_q = 1'b1;
        if (r.prox_q && r.st != IHC_IDLE && r.st != IHC_RUN) next_r.prox_seen = 1'b1;
        if (cmd[CMD_RESET_ERR]) begin
            next_r.lim_cw_err = 1'b0;
            next_r.lim_ccw_err = 1'b0;
        end
        if (cmd[CMD_IDX]) begin
            next_r.idx_pend = 1'b1;
            next_r.idx_dir = cmd[CMD_IDX_DIR];
        end
        case (r.st)
            IHC_IDLE: begin
                next_r.mot.run = 1'b0;
                next_r.mot.slow = 1'b0;
                next_r.prox_seen = 1'b0;
                if (begin_ok && (cmd[CMD_JOG_CW] || cmd[CMD_JOG_CCW] || cmd[CMD_REG])) begin
                    if (!(cmd[CMD_JOG_CCW] ? (lim_ccw || r.lim_ccw_err) : (lim_cw || r.lim_cw_err))) begin
                        next_r.st = IHC_RUN;
                        next_r.mv_jog = 1'b1;
                        next_r.mot.run = 1'b1;
                        next_r.mot.dir_ccw = cmd[CMD_JOG_CCW];
                    end
                end else if (begin_ok && r.idx_pend && start_rise) begin
                    next_r.idx_pend = cmd[CMD_IDX];
                    if (!(r.idx_dir ? (lim_ccw || r.lim_ccw_err) : (lim_cw || r.lim_cw_err))) begin
                        next_r.st = IHC_RUN;
                        next_r.mv_jog = 1'b0;
                        next_r.mot.run = 1'b1;
                        next_r.mot.dir_ccw = r.idx_dir;
                    end
                end else if (begin_ok && (cmd[CMD_HOME_CW] || cmd[CMD_HOME_CCW])) begin
                    next_r.dir_ccw = cmd[CMD_HOME_CCW];
                    next_r.mot.run = 1'b1;
                    next_r.mot.slow = 1'b0;
                    if ((cmd[CMD_HOME_CCW] ? lim_ccw : lim_cw) || (home_act && !prox_en)) begin
                        next_r.st = IHC_H_REV;
                        next_r.mot.dir_ccw = !cmd[CMD_HOME_CCW];
                    end else begin
                        next_r.st = IHC_H_FWD;
                        next_r.mot.dir_ccw = cmd[CMD_HOME_CCW];
                    end
                end
            end
            IHC_RUN: begin
                if (r.mv_jog && stop_rise) next_r.mot.ramp_stop = 1'b1;
                if (cmd[CMD_STOP]) next_r.mot.ramp_stop = 1'b1;
                if (profile_done) begin
                    next_r.st = IHC_IDLE;
                    next_r.mot.run = 1'b0;
                end
            end
            IHC_H_FWD: begin
                if (prox_en && r.prox_seen && !r.mot.slow) begin
                    next_r.mot.slow = 1'b1;
                end else if (prox_en && r.mot.slow && home_rise) begin
                    next_r.mot.halt_now = 1'b1;
                    next_r.mot.run = 1'b0;
                    next_r.st = IHC_IDLE;
                end else if (!prox_en && home_rise) begin
                    next_r.mot.ramp_stop = 1'b1;
                    next_r.st = IHC_H_DEC1;
                end
            end
            IHC_H_DEC1: begin
                if (profile_done) begin
                    next_r.st = IHC_H_P1;
                    next_r.mot.run = 1'b0;
                    next_r.pause_cnt = 32'(PAUSE_CYCLES);
                end
            end
            IHC_H_P1: begin
                next_r.pause_cnt = r.pause_cnt - 1'b1;
                if (r.pause_cnt <= 32'h1) begin
                    next_r.st = IHC_H_REV;
                    next_r.mot.run = 1'b1;
                    next_r.mot.dir_ccw = !h_ccw;
                end
            end
            IHC_H_REV: begin
                if (home_fall) next_r.mot.ramp_stop = 1'b1;
                if (home_fall) next_r.st = IHC_H_RET;
            end
            IHC_H_RET: begin
                if (profile_done) begin
                    next_r.st = IHC_H_P2;
                    next_r.mot.run = 1'b0;
                    next_r.pause_cnt = 32'(PAUSE_CYCLES);
                end
            end
            IHC_H_P2: begin
                next_r.pause_cnt = r.pause_cnt - 1'b1;
                if (r.pause_cnt <= 32'h1) begin
                    next_r.st = IHC_H_SLOW;
                    next_r.mot.run = 1'b1;
                    next_r.mot.slow = 1'b1;
                    next_r.mot.dir_ccw = h_ccw;
                end
            end
            IHC_H_SLOW: begin
                if (home_rise) begin
                    next_r.mot.halt_now = 1'b1;
                    next_r.mot.run = 1'b0;
                    next_r.st = IHC_IDLE;
                end
            end
            default: next_r.st = IHC_IDLE;
        endcase

        // overtravel while homing forward: stop at once, pause, then reverse
        if ((r.st == IHC_H_FWD || r.st == IHC_H_DEC1) && ot_fwd) begin
            next_r.mot.halt_now = 1'b1;
            next_r.mot.run = 1'b0;
            next_r.st = IHC_H_P1;
            next_r.pause_cnt = 32'(PAUSE_CYCLES);
        end else if (r.mot.run && (r.mot.dir_ccw ? lim_ccw : lim_cw) && r.st == IHC_RUN) begin
            next_r.mot.halt_now = 1'b1;
            next_r.mot.run = 1'b0;
            next_r.st = IHC_IDLE;
            if (r.mot.dir_ccw) next_r.lim_ccw_err = 1'b1;
            else next_r.lim_cw_err = 1'b1;
        end
        // emergency halt overrides everything; drive remains enabled
        if (estop_rise || (estop && r.st != IHC_IDLE)) begin
            next_r.mot.halt_now = 1'b1;
            next_r.mot.run = 1'b0;
            next_r.st = IHC_IDLE;
        end

        // ********************************************************
        // AXI4-Lite slave: one write, one read at a time
        // ********************************************************
        if (s_axi_awvalid && !r.aw_hold) begin
            next_r.aw_hold = 1'b1;
            next_r.awa = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && !r.w_hold) begin
            next_r.w_hold = 1'b1;
            next_r.wd = s_axi_wdata;
        end
        if (wr_fire) begin
            next_r.aw_hold = 1'b0;
            next_r.w_hold = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = RESP_OKAY;
            if (r.awa == ADDR_CFG) next_r.cfg = r.wd;
            else if (r.awa == ADDR_GEAR) next_r.gear_ratio = r.wd;
            else if (r.awa == ADDR_PRESET) next_r.mpos = r.wd[POS_W-1:0];
            else if (r.awa != ADDR_CMD) next_r.bresp = RESP_SLVERR;
        end
        if (r.bvalid && s_axi_bready) next_r.bvalid = 1'b0;
        if (rd_fire) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = RESP_OKAY;
            if (s_axi_araddr[7:0] == ADDR_CFG) next_r.rdata = r.cfg;
            else if (s_axi_araddr[7:0] == ADDR_STATUS)
                next_r.rdata = {15'h0, r.st, r.prox_seen, r.idx_pend, r.lim_ccw_err, r.lim_cw_err,
                                r.mot.run, act};
            else if (s_axi_araddr[7:0] == ADDR_MPOS) next_r.rdata = 32'(signed'(r.mpos));
            else if (s_axi_araddr[7:0] == ADDR_EPOS) next_r.rdata = 32'(signed'(r.epos));
            else if (s_axi_araddr[7:0] == ADDR_CAPT) next_r.rdata = 32'(signed'(r.capt));
            else if (s_axi_araddr[7:0] == ADDR_GEAR) next_r.rdata = r.gear_ratio;
            else begin
                next_r.rdata = 32'h0;
                next_r.rresp = RESP_SLVERR;
            end
        end
        if (r.rvalid && s_axi_rready) next_r.rvalid = 1'b0;
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.st <= IHC_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign s_axi_awready = !r.aw_hold;
    assign s_axi_wready = !r.w_hold;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign motion = r.mot;
    assign drive_enable = 1'b1;
    assign gear_step = r.gstep;
    assign gear_dir_ccw = r.gdir;
endmodule : ihc_top
`default_nettype wire

//--- sim/ihc_machine.sv
// machine model: step source, home and cw limit sensors, spare input
`timescale 1ns/1ps
`default_nettype none
module ihc_machine (
    input wire logic aclk,
    input wire logic aresetn,
    input wire ihc_pkg::ihc_motion_s motion,
    input wire logic ext,
    output logic [2:0] pin_in,
    output logic profile_done,
    output logic step_pulse,
    output int pos
);
    import ihc_pkg::*;
    logic [1:0] div;
    logic [2:0] dcnt;
    // one step every fourth cycle; a ramp takes a few cycles, so done lags the order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pos <= 40;
            div <= 2'h0;
            dcnt <= 3'h0;
        end else begin
            div <= div + 2'h1;
            dcnt <= motion.ramp_stop ? 3'h4 : (dcnt != 3'h0 ? dcnt - 3'h1 : 3'h0);
            if (step_pulse) pos <= motion.dir_ccw ? pos - 1 : pos + 1;
        end
    end
    assign step_pulse = motion.run && div == 2'h3;
    assign profile_done = dcnt == 3'h1;
    // home flag spans 20..29, cw end of travel from 60 on
    assign pin_in = {ext, pos >= 60, pos >= 20 && pos <= 29};
endmodule : ihc_machine
`default_nettype wire

//--- sim/ihc_top_sva.sv
// port checks for the homing control block
`timescale 1ns/1ps
`default_nettype none
module ihc_top_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire ihc_pkg::ihc_motion_s motion,
    input wire logic drive_enable
);
    import ihc_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // halts and ramps are single pulses; a halt takes run down without a ramp
    drive_stays_on_a: assert property (drive_enable) else $error("drive dropped");
    halt_pulse_a: assert property (motion.halt_now |=> !motion.halt_now) else $error("halt too long");
    halt_stops_run_a: assert property (motion.halt_now |-> !motion.run) else $error("run kept");
    ramp_pulse_a: assert property (motion.ramp_stop |=> !motion.ramp_stop) else $error("ramp too long");
    // bus answers keep the hand-over timing
    aw_held_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("aw not held");
    b_after_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
    b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("b repeated");
    r_after_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
endmodule : ihc_top_sva
bind ihc_top ihc_top_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .motion, .drive_enable);
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the homing control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ihc_pkg::*;
    localparam int PC = 20;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ext = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rdat;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, profile_done, step_pulse;
    logic drive_enable, gear_step, gear_dir_ccw;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [2:0] pin_in;
    ihc_motion_s motion;
    int pos, bad_count = 0, num_checks = 0, nh = 0, nr = 0, gap = 0, mgap = 0, nrev = 0;
    ihc_top #(.PAUSE_CYCLES(PC)) DUT (.aclk, .aresetn, .pin_in, .profile_done, .step_pulse, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .motion, .drive_enable, .gear_step,
        .gear_dir_ccw);
    ihc_machine u_mach (.aclk, .aresetn, .motion, .ext, .pin_in, .profile_done, .step_pulse, .pos);
    always #25 aclk = ~aclk;
    // pulse counts and longest standstill that ended in a restart
    always @(posedge aclk) begin
        nh += int'(motion.halt_now === 1'b1);
        nr += int'(motion.ramp_stop === 1'b1);
        nrev += int'(motion.run === 1'b1 && motion.dir_ccw === 1'b1);
        mgap = (motion.run === 1'b1 && gap > mgap) ? gap : mgap;
        gap = (motion.run === 1'b1) ? 0 : gap + 1;
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask : cyc
    // handshakes are judged at the falling edge, where the rising-edge updates have landed
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        s_axi_awaddr <= 32'(a);
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        forever begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready === 1'b1;
            w = s_axi_wvalid && s_axi_wready === 1'b1;
            b = s_axi_bvalid === 1'b1;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) break;
        end
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic ar, rv;
        s_axi_araddr <= 32'(a);
        s_axi_arvalid <= 1'b1;
        forever begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready === 1'b1;
            rv = s_axi_rvalid === 1'b1;
            rdat = s_axi_rdata;
            rr = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (rv) break;
        end
        #1;
    endtask : rd
    task automatic wt(input logic e);
        for (int i = 0; i < 2000; i++) begin
            @(negedge aclk);
            if (motion.run === e) break;
        end
        chk("run", 32'(motion.run), 32'(e));
        cyc(1);
    endtask : wt
    task automatic t_regs;
        wr(ADDR_CFG, 32'h800);
        cyc(6);
        rd(ADDR_STATUS);
        chk("in3", 32'(rdat[2]), 1);
        chk("still", 32'(motion.run), 0);
        chk("gear", 32'(gear_step), 0);
        rd(ADDR_CFG);
        chk("cfg", rdat, 32'h800);
        wr(ADDR_PRESET, 32'h00800000);
        rd(ADDR_MPOS);
        chk("mpos", rdat, 32'hFF800000);
        rd(8'h20);
        chk("resp", {30'h0, rr}, 32'(RESP_SLVERR));
        chk("rdat", rdat, 32'h0);
    endtask : t_regs
    task automatic t_limit;
        wr(ADDR_CFG, 32'(FN_CWLIM) << 3);
        wr(ADDR_CMD, 32'h1);
        wt(1'b1);
        wt(1'b0);
        chk("halt", 32'(nh != 0), 1);
        wr(ADDR_CMD, 32'h1);
        cyc(10);
        chk("refuse", 32'(motion.run), 0);
        wr(ADDR_CMD, 32'h2);
        wt(1'b1);
        wr(ADDR_CMD, 32'h40);
        wt(1'b0);
    endtask : t_limit
    task automatic t_home;
        wr(ADDR_CFG, (32'(FN_CWLIM) << 3) | 32'(FN_HOME));
        wr(ADDR_CMD, 32'h80);
        wr(ADDR_CMD, 32'h10);
        wt(1'b1);
        mgap = 0;
        nrev = 0;
        for (int i = 0; i < 400; i++) begin
            rd(ADDR_STATUS);
            if (rdat[16:8] === IHC_IDLE) break;
        end
        chk("idle", 32'(rdat[16:8]), 32'(IHC_IDLE));
        chk("home", 32'(pin_in[0]), 1);
        chk("rev", 32'(nrev != 0), 1);
        chk("pause", 32'(mgap >= PC && mgap <= PC + 12), 1);
    endtask : t_home
    task automatic t_estop;
        wr(ADDR_CFG, 32'(FN_ESTOP) << 6);
        wr(ADDR_CMD, 32'h1);
        wt(1'b1);
        nh = 0;
        ext <= 1'b1;
        wt(1'b0);
        chk("halt", 32'(nh != 0), 1);
        chk("drv", 32'(drive_enable), 1);
        wr(ADDR_CMD, 32'h2);
        cyc(10);
        chk("blocked", 32'(motion.run), 0);
        ext <= 1'b0;
    endtask : t_estop
    task automatic t_index;
        wr(ADDR_CFG, 32'(FN_START) << 6);
        wr(ADDR_CMD, 32'h208);
        cyc(10);
        chk("wait", 32'(motion.run), 0);
        rd(ADDR_STATUS);
        chk("pend", 32'(rdat[6]), 1);
        ext <= 1'b1;
        wt(1'b1);
        wr(ADDR_CMD, 32'h40);
        wt(1'b0);
        ext <= 1'b0;
    endtask : t_index
    task automatic t_jog;
        wr(ADDR_CFG, 32'(FN_STOPJOG) << 6);
        wr(ADDR_CMD, 32'h1);
        wt(1'b1);
        nr = 0;
        ext <= 1'b1;
        wt(1'b0);
        chk("ramp", 32'(nr != 0), 1);
        ext <= 1'b0;
    endtask : t_jog
    task automatic t_prox;
        wr(ADDR_CFG, (32'h1 << CFG_PROX) | (32'(FN_ESTOP) << 6) | 32'(FN_HOME));
        wr(ADDR_CMD, 32'h20);
        cyc(30);
        chk("ign", 32'(motion.run & !motion.slow), 1);
        wr(ADDR_CMD, 32'h100);
        cyc(2);
        chk("slow", 32'(motion.slow), 1);
        ext <= 1'b1;
        wt(1'b0);
    endtask : t_prox
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    // ******************************************
    // reset, scenarios, watchdog
    // ******************************************
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        cyc(1);
        t_regs();
        t_limit();
        t_home();
        t_estop();
        t_index();
        t_jog();
        t_prox();
        summarize();
    end
    initial begin
        #2000000;
        bad_count++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire
